/* hbr_cpu_model.sv */
/* hbr_cpu_model: processor on the hbr_regs command port.
   assumes one calling process on clk. */
module hbr_cpu_model (
    // clock and read answer
    input  wire logic        clk,
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    // command port
    output logic             cmd_valid = 1'b0,
    output logic             wr_valid  = 1'b0,
    output logic             rd_req    = 1'b0,
    output logic      [7:0]  cmd_code  = 8'h00,
    output logic      [15:0] wr_data   = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines invert, so stale data never looks live
    task automatic cmd(input logic [7:0] c);
        @(posedge clk) {cmd_valid, cmd_code} <= {1'b1, c};
        @(posedge clk) {cmd_valid, cmd_code} <= {1'b0, ~c};
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd(c);
        {wr_valid, wr_data} <= {1'b1, d};
        @(posedge clk) {wr_valid, wr_data} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        cmd(c);
        rd_req <= 1'b1;
        @(posedge clk) rd_req <= 1'b0;
        @(posedge clk) d = rd_valid ? rd_data : 16'hxxxx;
    endtask
endmodule

/* hbr_flags.sv */
/*
 * hbr_flags: loaded and consumed flags for the three list buffers.
 * Assumes one-cycle event pulses on clk from the surrounding logic.
 */
module hbr_flags
    import hbr_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // events and flags
    hbr_flags_if.tracker    fl
);
    logic [2:0] loaded_q;
    logic [2:0] consumed_q;

    // loaded: set by a completed fill, cleared once the controller reads it;
    // a completed fill in the same cycle as a consume keeps the flag set
    always_ff @(posedge clk) begin
        if (srst || fl.soft_reset) begin
            loaded_q <= FLAGS_RESET;
        end else begin
            loaded_q <= (loaded_q & ~fl.consume) | fl.fill_done;
        end
    end

    // consumed: set when the controller reads a buffer, dropped when software
    // begins refilling it; the set wins a same-cycle clash
    always_ff @(posedge clk) begin
        if (srst || fl.soft_reset) begin
            consumed_q <= FLAGS_RESET;
        end else begin
            consumed_q <= (consumed_q & ~fl.fill_start) | fl.consume;
        end
    end

    assign fl.loaded   = loaded_q;
    assign fl.consumed = consumed_q;
endmodule

/* hbr_flags_if.sv */
/*
 * hbr_flags_if: carries buffer load/consume events and the resulting
 * flags between the register bank and the flag tracker.
 * Assumes both ends run on the same clk.
 */
interface hbr_flags_if;
    logic [2:0] fill_start;
    logic [2:0] fill_done;
    logic [2:0] consume;
    logic       soft_reset;
    logic [2:0] loaded;
    logic [2:0] consumed;
    modport bank    (output fill_start, fill_done, consume, soft_reset,
                     input  loaded, consumed);
    modport tracker (input  fill_start, fill_done, consume, soft_reset,
                     output loaded, consumed);
endinterface

/* hbr_pkg.sv */
/*
 * hbr_pkg: command codes, field positions and reset values for the
 * host buffer RAM control register group.
 * Assumes a 16-bit command/data parallel port driven by logic on clk.
 */
package hbr_pkg;
    localparam logic [7:0]  CMD_SCRATCH_RD  = 8'h28;
    localparam logic [7:0]  CMD_SCRATCH_WR  = 8'ha8;
    localparam logic [7:0]  CMD_SOFT_RESET  = 8'ha9;
    localparam logic [7:0]  CMD_ISO_LEN_RD  = 8'h2a;
    localparam logic [7:0]  CMD_ISO_LEN_WR  = 8'haa;
    localparam logic [7:0]  CMD_ACK_LEN_RD  = 8'h2b;
    localparam logic [7:0]  CMD_ACK_LEN_WR  = 8'hab;
    localparam logic [7:0]  CMD_STATE_RD    = 8'h2c;

    localparam logic [15:0] SCRATCH_RESET   = 16'h0000;
    localparam logic [15:0] ISO_LEN_RESET   = 16'h0000;
    localparam logic [15:0] ACK_LEN_RESET   = 16'h0000;
    localparam logic [2:0]  FLAGS_RESET     = 3'h0;
    localparam logic [7:0]  CMD_RESET       = 8'h00;
    localparam logic [15:0] RD_DATA_RESET   = 16'h0000;

    // buffer index inside the flag vectors
    localparam int          BUF_ISO_FIRST   = 0;
    localparam int          BUF_ISO_SECOND  = 1;
    localparam int          BUF_ACK         = 2;
    // field positions in buffer_state
    localparam int          LOADED_LSB      = 0;
    localparam int          CONSUMED_LSB    = 3;
    localparam logic [16:0] RAM_BYTES       = 17'h01000;

    typedef enum logic [2:0] {
        HBR_IDLE  = 3'b001,
        HBR_WDATA = 3'b010,
        HBR_RDATA = 3'b100
    } hbr_state_t;
endpackage

/* hbr_regs.sv */
/*
 * hbr_regs: command-addressed scratch, soft reset, list length and
 * buffer state registers of the host side.
 * Assumes the processor port and the buffer event inputs are driven by
 * logic on clk; pin synchronisation sits outside this block.
 */
// How it works
// - 16-bit scratch, read 28 write a8
// - command a9 resets host registers, not RAM
// - one iso length sets both iso buffers
// - 16-bit ack length, read 2b write ab
// - bits 5..3 show buffers consumed by controller
// - bits 2..0 show buffers holding data
// - status read-only via 2c, upper bits zero
module hbr_regs
    import hbr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // processor command port
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        wr_valid,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_req,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    // buffer activity from the controller core
    input  wire logic [2:0]  fill_start,
    input  wire logic [2:0]  fill_done,
    input  wire logic [2:0]  consume,
    // lengths to the buffer allocator
    output logic      [15:0] iso_first_length,
    output logic      [15:0] iso_second_length,
    output logic      [15:0] ack_length,
    output logic             length_overflow
);
    hbr_state_t  state_q;
    logic [7:0]  cmd_q;
    logic [15:0] scratch_q;
    logic [15:0] iso_len_q;
    logic [15:0] ack_len_q;
    logic [15:0] rd_data_q;
    logic        rd_valid_q;
    logic        soft_rst_q;
    logic        overflow_q;
    logic [15:0] state_word;
    logic        host_rst;

    // decoded strobes and the ram budget sum
    logic        soft_hit;
    logic        rd_take;
    logic        scratch_wr;
    logic        iso_len_wr;
    logic        ack_len_wr;
    logic [17:0] len_total;

    hbr_flags_if fl ();

    assign fl.fill_start = fill_start;
    assign fl.fill_done  = fill_done;
    assign fl.consume    = consume;
    assign fl.soft_reset = soft_rst_q;

    hbr_flags hbr_flags_inst (
        .clk  (clk),
        .srst (srst),
        .fl   (fl)
    );

    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == CMD_SCRATCH_WR || c == CMD_ISO_LEN_WR ||
               c == CMD_ACK_LEN_WR;
    endfunction

    // ack plus both iso lists; 18 bits so a doubled iso length cannot wrap
    function automatic logic [17:0] len_sum(input logic [15:0] ack,
                                            input logic [15:0] iso);
        return {2'b00, ack} + {1'b0, iso, 1'b0};
    endfunction

    // soft reset takes effect one cycle after the code lands; a command in
    // that cycle is dropped along with everything else
    // the buffer ram sits outside this block; no reset path reaches it
    assign soft_hit = cmd_valid && cmd_code == CMD_SOFT_RESET;
    assign host_rst = srst || soft_rst_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= soft_hit;
        end
    end

    // command phase then one data phase; a fresh code in a data phase
    // aborts it, so a processor that lost count can always start over
    always_ff @(posedge clk) begin
        if (host_rst) begin
            state_q <= HBR_IDLE;
        end else begin
            case (state_q)
                HBR_IDLE: begin
                    if (cmd_valid && !soft_hit) begin
                        state_q <= is_write_cmd(cmd_code) ? HBR_WDATA
                                                          : HBR_RDATA;
                    end
                end
                HBR_WDATA: begin
                    if (wr_valid || cmd_valid) begin
                        state_q <= HBR_IDLE;
                    end
                end
                HBR_RDATA: begin
                    if (rd_req || cmd_valid) begin
                        state_q <= HBR_IDLE;
                    end
                end
                default: state_q <= HBR_IDLE;
            endcase
        end
    end

    // code held for the data phase that follows it
    always_ff @(posedge clk) begin
        if (host_rst) begin
            cmd_q <= CMD_RESET;
        end else if (state_q == HBR_IDLE && cmd_valid && !soft_hit) begin
            cmd_q <= cmd_code;
        end
    end

    function automatic logic wr_hit(input hbr_state_t s, input logic v,
                                    input logic [7:0] c, input logic [7:0] k);
        return s == HBR_WDATA && v && c == k;
    endfunction

    // write strobes land only in the data phase of their own code
    assign scratch_wr = wr_hit(state_q, wr_valid, cmd_q, CMD_SCRATCH_WR);
    assign iso_len_wr = wr_hit(state_q, wr_valid, cmd_q, CMD_ISO_LEN_WR);
    assign ack_len_wr = wr_hit(state_q, wr_valid, cmd_q, CMD_ACK_LEN_WR);
    assign rd_take    = state_q == HBR_RDATA && rd_req;

    always_ff @(posedge clk) begin
        if (host_rst) begin
            scratch_q <= SCRATCH_RESET;
        end else if (scratch_wr) begin
            scratch_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (host_rst) begin
            iso_len_q <= ISO_LEN_RESET;
        end else if (iso_len_wr) begin
            iso_len_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (host_rst) begin
            ack_len_q <= ACK_LEN_RESET;
        end else if (ack_len_wr) begin
            ack_len_q <= wr_data;
        end
    end

    // reserved bits tie to zero; no write code reaches this word
    always_comb begin
        state_word = 16'h0000;
        state_word[LOADED_LSB +: 3]   = fl.loaded;
        state_word[CONSUMED_LSB +: 3] = fl.consumed;
    end

    // unknown read codes answer zero rather than stalling the processor
    always_ff @(posedge clk) begin
        if (host_rst) begin
            rd_data_q <= RD_DATA_RESET;
        end else begin
            if (rd_take) begin
                case (cmd_q)
                    CMD_SCRATCH_RD: rd_data_q <= scratch_q;
                    CMD_ISO_LEN_RD: rd_data_q <= iso_len_q;
                    CMD_ACK_LEN_RD: rd_data_q <= ack_len_q;
                    CMD_STATE_RD:   rd_data_q <= state_word;
                    default:        rd_data_q <= 16'h0000;
                endcase
            end
        end
    end

    // answer strobe lasts one cycle; the data above holds until the next
    // answer, so a slow processor may fetch it later from the port
    always_ff @(posedge clk) begin
        if (host_rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_take;
        end
    end

    // sum is combinational; the flag is registered and lags one cycle
    assign len_total = len_sum(ack_len_q, iso_len_q);

    // the limit is software's duty; the flag only reports a bad setting
    always_ff @(posedge clk) begin
        if (host_rst) begin
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= len_total > {1'b0, RAM_BYTES};
        end
    end

    assign rd_data           = rd_data_q;
    assign rd_valid          = rd_valid_q;
    assign iso_first_length  = iso_len_q;
    assign iso_second_length = iso_len_q;
    assign ack_length        = ack_len_q;
    assign length_overflow   = overflow_q;
endmodule

/* hbr_regs_chk.sv */
/* hbr_regs_chk: port checks of hbr_regs.
   assumes one clk, srst synchronous active high. */
module hbr_regs_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // command port
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic        wr_valid,
    input wire logic [15:0] wr_data,
    input wire logic        rd_req,
    input wire logic [15:0] rd_data,
    input wire logic        rd_valid,
    // lengths
    input wire logic [15:0] iso_first_length,
    input wire logic [15:0] iso_second_length,
    input wire logic [15:0] ack_length,
    input wire logic        length_overflow
);
    logic       ph_q;
    logic [7:0] code_q;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // soft reset opens no data phase
    always_ff @(posedge clk) begin
        if (srst) ph_q <= 1'b0;
        else if (cmd_valid) ph_q <= !ph_q && cmd_code != 8'ha9;
        else if (wr_valid || rd_req) ph_q <= 1'b0;
    end
    always_ff @(posedge clk) if (cmd_valid) code_q <= cmd_code;
    a_iso_equal: assert property (iso_first_length == iso_second_length)
        else $error("iso lengths differ");
    a_soft_clear: assert property (cmd_valid && !ph_q && cmd_code == 8'ha9
        |=> ##2 ack_length == 16'h0) else $error("soft reset missed");
    a_ack_write: assert property (ph_q && wr_valid && code_q == 8'hab
        |=> ack_length == $past(wr_data)) else $error("ack write lost");
    a_iso_write: assert property (ph_q && wr_valid && code_q == 8'haa
        |=> iso_first_length == $past(wr_data)) else $error("iso write lost");
    a_ack_read: assert property (ph_q && rd_req && code_q == 8'h2b
        |=> rd_valid && rd_data == ack_length) else $error("ack read bad");
    a_state_rsvd: assert property (ph_q && rd_req && code_q == 8'h2c
        |=> rd_data[15:6] == 10'h0) else $error("reserved bits set");
    a_rd_pulse: assert property (rd_valid |=> !rd_valid) else $error("long read");
    a_ram_limit: assert property (length_overflow ==
        ({2'h0, $past(ack_length)} + {1'h0, $past(iso_first_length), 1'h0}
        > 18'h01000)) else $error("overflow flag wrong");
    c_state: cover property (ph_q && rd_req && code_q == 8'h2c);
    c_flag: cover property (length_overflow);
    c_soft: cover property (cmd_valid && cmd_code == 8'ha9);
endmodule
bind hbr_regs hbr_regs_chk hbr_regs_chk_inst (
    .clk               (clk),
    .srst              (srst),
    .cmd_valid         (cmd_valid),
    .cmd_code          (cmd_code),
    .wr_valid          (wr_valid),
    .wr_data           (wr_data),
    .rd_req            (rd_req),
    .rd_data           (rd_data),
    .rd_valid          (rd_valid),
    .iso_first_length  (iso_first_length),
    .iso_second_length (iso_second_length),
    .ack_length        (ack_length),
    .length_overflow   (length_overflow)
);

/* host_buffer_ram_control_regs_bench.sv */
/* host_buffer_ram_control_regs_bench: self-checking bench of hbr_regs.
   assumes hbr_cpu_model drives the command port. */
module host_buffer_ram_control_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import hbr_pkg::*;
    logic        clk = 1'b0, srst = 1'b1;
    logic [2:0]  fill_start = 3'h0, fill_done = 3'h0, consume = 3'h0;
    logic        cmd_valid, wr_valid, rd_req, rd_valid, length_overflow;
    logic [7:0]  cmd_code;
    logic [15:0] wr_data, rd_data, ack_length;
    logic [15:0] iso_first_length, iso_second_length;
    logic [7:0]  z[4] = '{CMD_SCRATCH_RD, CMD_ISO_LEN_RD, CMD_ACK_LEN_RD,
                          CMD_STATE_RD};
    int          err_total = 0, checked = 0;
    hbr_regs hbr_regs_inst (
        .clk               (clk),
        .srst              (srst),
        .cmd_valid         (cmd_valid),
        .cmd_code          (cmd_code),
        .wr_valid          (wr_valid),
        .wr_data           (wr_data),
        .rd_req            (rd_req),
        .rd_data           (rd_data),
        .rd_valid          (rd_valid),
        .fill_start        (fill_start),
        .fill_done         (fill_done),
        .consume           (consume),
        .iso_first_length  (iso_first_length),
        .iso_second_length (iso_second_length),
        .ack_length        (ack_length),
        .length_overflow   (length_overflow)
    );
    hbr_cpu_model hbr_cpu_model_inst (
        .clk       (clk),
        .rd_valid  (rd_valid),
        .rd_data   (rd_data),
        .cmd_valid (cmd_valid),
        .wr_valid  (wr_valid),
        .rd_req    (rd_req),
        .cmd_code  (cmd_code),
        .wr_data   (wr_data)
    );
    initial forever #5 clk = ~clk;
    task automatic conclude;
        $display("%0d mismatches in %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, g);
        checked++;
        if (g !== e) err_total++;
        if (g !== e) $display("wrong value %s exp %h got %h", n, e, g);
    endtask
    task automatic rc(logic [7:0] c, logic [15:0] e, string n);
        logic [15:0] d;
        hbr_cpu_model_inst.rd(c, d);
        chk(n, e, d);
    endtask
    task automatic ev(logic [2:0] s, f, u);
        @(posedge clk) {fill_start, fill_done, consume} <= {s, f, u};
        @(posedge clk) {fill_start, fill_done, consume} <= 9'h0;
    endtask
    task automatic t_reset;
        foreach (z[i]) rc(z[i], 16'h0, "reset value");
        chk("overflow", 16'h0, {15'h0, length_overflow});
    endtask
    task automatic t_len;
        hbr_cpu_model_inst.wr(CMD_ISO_LEN_WR, 16'h0400);
        hbr_cpu_model_inst.wr(CMD_ACK_LEN_WR, 16'h0800);
        rc(CMD_ACK_LEN_RD, 16'h0800, "ack length");
        rc(CMD_ISO_LEN_RD, 16'h0400, "iso length");
        chk("iso first", 16'h0400, iso_first_length);
        chk("iso second", 16'h0400, iso_second_length);
        chk("ack out", 16'h0800, ack_length);
        // exactly the whole ram is still a legal split
        chk("overflow", 16'h0, {15'h0, length_overflow});
        // one byte past the ram must raise the flag
        hbr_cpu_model_inst.wr(CMD_ACK_LEN_WR, 16'h0801);
        repeat (2) @(posedge clk);
        #1 chk("overflow", 16'h1, {15'h0, length_overflow});
        // doubled iso length needs the 18th bit
        hbr_cpu_model_inst.wr(CMD_ACK_LEN_WR, 16'h0002);
        hbr_cpu_model_inst.wr(CMD_ISO_LEN_WR, 16'hffff);
        repeat (2) @(posedge clk);
        #1 chk("overflow", 16'h1, {15'h0, length_overflow});
        // back to a legal split for the later scenarios
        hbr_cpu_model_inst.wr(CMD_ISO_LEN_WR, 16'h0400);
        repeat (2) @(posedge clk);
        #1 chk("overflow", 16'h0, {15'h0, length_overflow});
    endtask
    task automatic t_flags;
        ev(3'h0, 3'h7, 3'h0);
        rc(CMD_STATE_RD, 16'h0007, "state");
        ev(3'h0, 3'h0, 3'h7);
        rc(CMD_STATE_RD, 16'h0038, "state");
        ev(3'h2, 3'h0, 3'h0);
        rc(CMD_STATE_RD, 16'h0028, "state");
        // set beats clear when both land in one cycle
        ev(3'h2, 3'h4, 3'h6);
        rc(CMD_STATE_RD, 16'h003c, "state");
    endtask
    task automatic t_soft;
        hbr_cpu_model_inst.wr(CMD_ACK_LEN_WR, 16'h0123);
        hbr_cpu_model_inst.wr(CMD_SCRATCH_WR, 16'ha5c3);
        rc(CMD_SCRATCH_RD, 16'ha5c3, "scratch");
        hbr_cpu_model_inst.cmd(CMD_SOFT_RESET);
        foreach (z[i]) rc(z[i], 16'h0, "after soft reset");
    endtask
    task automatic t_hard;
        hbr_cpu_model_inst.wr(CMD_SCRATCH_WR, 16'h5a3c);
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rc(CMD_SCRATCH_RD, 16'h0, "after srst");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_len;
        t_flags;
        t_soft;
        t_hard;
        conclude;
    end
endmodule
